// File: design/rls_pkg.sv
/*
 Constants, timing figures and state codes of the pixel-to-serial-lane transmitter.
 Assumes a single 100 MHz system clock that samples every pin, including the pixel clock.
*/
// Overview of operation
// [R1] Serial bit lasts one seventh pixel period single, two sevenths dual.
// [R2] Bit 0 goes out first; bit 6 occupies the seventh interval.
// [R3] Lanes stay quiet until lock time after enable with running pixel clock.
// [R4] Dual-mode pixels reach lanes after a fixed pipeline from capture; the code holds pairs in a FIFO popped at word ends, so the delay varies.
// [R5] Mode low uses lane group A only; high uses groups A and B.
// [R6] Capture on rising pixel clock edge when select high, falling when low.
// [R7] Dual mode: first pixel after enable rise to A, next to B; blanking even.
// [R8] Power-down low stops timing and disables all lane drivers until high.
// [R9] Bit timing derives from the pixel clock; clock lane marks word boundaries.
package rls_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned LOCK_TIME_MS = 1;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned LOCK_CYCLES = LOCK_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned PIX_W = 27;
  localparam int unsigned WORD_W = 28;
  localparam int unsigned LANES = 4;
  localparam int unsigned BITS = 7;
  localparam logic [2:0] FIRST_BIT = 3'h0;
  localparam logic [2:0] LAST_BIT = 3'h6;
  localparam logic [2:0] CLK_HIGH_BITS = 3'h4;
  localparam int unsigned DUAL_LATENCY_PIX = 9;
  localparam int unsigned IN_W = 31;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_LOCK = 2'b01,
    ST_RUN = 2'b10
  } rls_state_t;
endpackage : rls_pkg

// File: design/rls_fifo.sv
/*
 Synchronous FIFO with valid and ready on both sides and registered read data.
 Assumes one clock; clr_i empties it synchronously.
*/
module rls_fifo #(
  parameter int unsigned WIDTH = 54,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clr_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = DEPTH[AW:0];

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("FIFO depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  logic ov_q;
  logic [WIDTH-1:0] out_q;

  wire push = in_valid_i && (cnt_q != FULL);
  wire load = (cnt_q != '0) && (!ov_q || out_ready_i);

  assign in_ready_o = cnt_q != FULL;
  assign out_valid_o = ov_q;
  assign out_data_o = out_q;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'b0;
      out_q <= '0;
    end else if (clr_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'b0;
    end else begin
      wr_q <= push ? wr_q + 1'b1 : wr_q;
      rd_q <= load ? rd_q + 1'b1 : rd_q;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
      if (load) begin
        out_q <= mem[rd_q];
      end
      ov_q <= load || (ov_q && !out_ready_i);
    end
  end
endmodule : rls_fifo

// File: design/rls_serializer.sv
/*
 Pixel capture, single or dual lane-group word serialisation, lock timing and power-down.
 Assumes all inputs are asynchronous pins sampled by clk_i; the pixel clock is far slower than clk_i.
*/
module rls_serializer
  import rls_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES_P = LOCK_CYCLES,
  parameter int unsigned PER_W = 16,
  parameter int unsigned FIFO_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic pix_clk_i,
  input wire logic [7:0] red_i,
  input wire logic [7:0] green_i,
  input wire logic [7:0] blue_i,
  input wire logic hsync_i,
  input wire logic vsync_i,
  input wire logic de_i,
  input wire logic pixel_output_mode_select_i,
  input wire logic capture_edge_select_i,
  input wire logic power_down_n_i,
  output logic [LANES-1:0] lane_group_a_data_o,
  output logic lane_group_a_clk_o,
  output logic lane_group_a_en_o,
  output logic [LANES-1:0] lane_group_b_data_o,
  output logic lane_group_b_clk_o,
  output logic lane_group_b_en_o,
  output logic locked_o,
  output logic overflow_o
);
  localparam int unsigned LOCK_W = $clog2(LOCK_CYCLES_P + 1);
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYCLES_P - 1);

  if (LOCK_CYCLES_P < 1) begin : g_lock_chk
    $error("Lock count must be at least one");
  end
  if (PER_W < 4) begin : g_per_chk
    $error("Period counter too narrow");
  end

  function automatic logic [PER_W:0] div7(input logic [PER_W:0] v);
    logic [PER_W:0] q;
    q = v / (PER_W + 1)'(BITS);
    div7 = (q == '0) ? (PER_W + 1)'(1) : q;
  endfunction : div7

  function automatic logic [LANES-1:0] lane_bits(input logic [WORD_W-1:0] w, input logic [2:0] pos);
    logic [LANES-1:0] r;
    r = '0;
    for (int l = 0; l < LANES; l++) begin
      r[l] = w[l * BITS + int'(pos)];
    end
    lane_bits = r;
  endfunction : lane_bits

  // Two-stage synchroniser for every pin.
  logic [IN_W-1:0] s1_q, s2_q;
  wire [IN_W-1:0] in_w = {power_down_n_i, capture_edge_select_i, pixel_output_mode_select_i,
                          de_i, vsync_i, hsync_i, blue_i, green_i, red_i, pix_clk_i};
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= in_w;
      s2_q <= s1_q;
    end
  end

  wire pclk = s2_q[0];
  wire [PIX_W-1:0] pix = s2_q[PIX_W:1];
  wire de = s2_q[PIX_W];
  wire mode = s2_q[PIX_W+1];
  wire edge_sel = s2_q[PIX_W+2];
  wire pdn = s2_q[PIX_W+3];

  rls_state_t state_q;
  logic pclk_q, de_q, phase_q, overflow_q;
  logic [PIX_W-1:0] half_q;
  logic [PER_W-1:0] per_cnt_q, period_q;
  logic [1:0] seen_q;
  logic [LOCK_W-1:0] lock_q;
  logic [PER_W:0] bit_cnt_q;
  logic [2:0] pos_q;
  logic [WORD_W-1:0] word_a_q, word_b_q;

  wire run = state_q == ST_RUN;
  wire off = state_q == ST_OFF;
  wire cap = edge_sel ? (pclk && !pclk_q) : (!pclk && pclk_q); // [R6]
  wire per_ok = seen_q == 2'h2;
  wire de_rise = de && !de_q;
  wire [PER_W:0] len_w = div7(mode ? {period_q, 1'b0} : {1'b0, period_q}); // [R1]
  wire ben = run && (bit_cnt_q >= len_w - 1'b1);
  wire wrap = ben && (pos_q == LAST_BIT);
  wire [2:0] npos = (pos_q == LAST_BIT) ? FIRST_BIT : pos_q + 3'h1; // [R2]

  wire f_ready, f_valid;
  wire [2*PIX_W-1:0] f_data;
  wire second = mode && phase_q && !de_rise;
  wire push = run && cap && (!mode || second);
  wire [2*PIX_W-1:0] push_data = mode ? {pix, half_q} : {{PIX_W{1'b0}}, pix}; // [R7]
  wire pop = wrap && f_valid; // [R4]
  wire [PIX_W-1:0] f_lo = f_data[PIX_W-1:0];
  wire [WORD_W-1:0] load_a = f_valid ? {1'b0, f_lo} : '0;
  wire [WORD_W-1:0] load_b = f_valid ? {1'b0, f_data[2*PIX_W-1:PIX_W]} : '0;
  wire [WORD_W-1:0] nxt_a = wrap ? load_a : word_a_q;
  wire [WORD_W-1:0] nxt_b = wrap ? load_b : word_b_q;

  rls_fifo #(
    .WIDTH(2 * PIX_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clr_i(off),
    .in_valid_i(push),
    .in_data_i(push_data),
    .in_ready_o(f_ready),
    .out_valid_o(f_valid),
    .out_data_o(f_data),
    .out_ready_i(pop)
  );

  // Power state and lock timer.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ST_OFF;
      lock_q <= '0;
    end else begin
      unique case (state_q)
        ST_OFF: begin
          lock_q <= '0;
          state_q <= pdn ? ST_LOCK : ST_OFF;
        end
        ST_LOCK: begin
          lock_q <= per_ok ? lock_q + 1'b1 : '0; // [R3]
          state_q <= !pdn ? ST_OFF : ((per_ok && lock_q == LOCK_LAST) ? ST_RUN : ST_LOCK);
        end
        ST_RUN: begin
          state_q <= pdn ? ST_RUN : ST_OFF; // [R8]
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  // Pixel period measurement and capture pairing.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pclk_q <= 1'b0;
      per_cnt_q <= '0;
      period_q <= '0;
      seen_q <= '0;
      de_q <= 1'b0;
      phase_q <= 1'b0;
      half_q <= '0;
      overflow_q <= 1'b0;
    end else begin
      pclk_q <= pclk;
      if (off) begin
        per_cnt_q <= '0;
        seen_q <= '0;
        phase_q <= 1'b0;
        de_q <= 1'b0;
        overflow_q <= 1'b0;
      end else if (cap) begin
        per_cnt_q <= '0;
        period_q <= per_cnt_q + 1'b1; // [R9]
        seen_q <= per_ok ? seen_q : seen_q + 2'h1;
        de_q <= de;
        phase_q <= mode && !second; // [R7]
        half_q <= pix;
        overflow_q <= overflow_q || (push && !f_ready);
      end else if (per_cnt_q != '1) begin
        per_cnt_q <= per_cnt_q + 1'b1;
      end
    end
  end

  // Bit timing, word load and lane drivers.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bit_cnt_q <= '0;
      pos_q <= LAST_BIT;
      word_a_q <= '0;
      word_b_q <= '0;
      lane_group_a_data_o <= '0;
      lane_group_b_data_o <= '0;
      lane_group_a_clk_o <= 1'b0;
      lane_group_b_clk_o <= 1'b0;
    end else if (!run) begin
      bit_cnt_q <= '0;
      pos_q <= LAST_BIT;
      lane_group_a_data_o <= '0; // [R8]
      lane_group_b_data_o <= '0;
      lane_group_a_clk_o <= 1'b0;
      lane_group_b_clk_o <= 1'b0;
    end else if (ben) begin
      bit_cnt_q <= '0;
      pos_q <= npos; // [R2]
      word_a_q <= nxt_a;
      word_b_q <= nxt_b;
      lane_group_a_data_o <= lane_bits(nxt_a, npos);
      lane_group_b_data_o <= mode ? lane_bits(nxt_b, npos) : '0; // [R5]
      lane_group_a_clk_o <= npos < CLK_HIGH_BITS; // [R9]
      lane_group_b_clk_o <= mode && (npos < CLK_HIGH_BITS);
    end else begin
      bit_cnt_q <= bit_cnt_q + 1'b1; // [R1]
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lane_group_a_en_o <= 1'b0;
      lane_group_b_en_o <= 1'b0;
      locked_o <= 1'b0;
      overflow_o <= 1'b0;
    end else begin
      lane_group_a_en_o <= run && pdn; // [R8]
      lane_group_b_en_o <= run && pdn && mode; // [R5]
      locked_o <= run;
      overflow_o <= overflow_q;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_word_start;
    ben && pos_q == LAST_BIT;
  endsequence

  sequence s_first_bit;
    pos_q == FIRST_BIT;
  endsequence

  a_bit_first: assert property (s_word_start |=> s_first_bit) // [R2]
    else $error("Word did not restart at bit zero");
  a_bit_step: assert property (ben && pos_q != LAST_BIT |=> pos_q == $past(pos_q) + 3'h1) // [R2]
    else $error("Bit position did not advance by one");
  a_bit_width: assert property (run && ben && len_w > 1 && $stable(len_w) |=> !ben) // [R1]
    else $error("Bit interval shorter than derived length");
  a_lock_wait: assert property ($rose(run) |-> $past(lock_q) == LOCK_LAST && $past(per_ok)) // [R3]
    else $error("Lanes enabled before lock time");
  a_group_b_mode: assert property (lane_group_b_en_o |-> $past(mode)) // [R5]
    else $error("Group B driven in single mode");
  a_edge_choice: assert property (cap |-> (edge_sel ? $rose(pclk) : $fell(pclk))) // [R6]
    else $error("Capture on the wrong pixel clock edge");
  a_pair_start: assert property (!off && cap && mode && de_rise |=> phase_q) // [R7]
    else $error("First pixel after enable rise not sent to group A");
  a_pdn_quiet: assert property (!pdn |-> ##2 (!lane_group_a_en_o && !lane_group_b_en_o && lane_group_a_data_o == '0)) // [R8]
    else $error("Drivers active during power down");
  a_clk_mark: assert property (run && ben && npos == FIRST_BIT |=> lane_group_a_clk_o) // [R9]
    else $error("Clock lane not high at word start");
  a_pop_fifo: assert property (wrap && f_valid |=> word_a_q == {1'b0, $past(f_lo)}) // [R4]
    else $error("Word not loaded from the pipeline");
endmodule : rls_serializer

// File: test/rls_rx_model.sv
/*
 Behavioural receiver of one lane group: rebuilds 28-bit words.
 Assumes bl_i system clocks per serial bit; it only samples and never drives.
*/
module rls_rx_model (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic [3:0] bl_i,
  input wire logic lane_clk_i,
  input wire logic [3:0] lane_data_i,
  output logic [27:0] word_o,
  output logic got_o,
  output logic [7:0] hi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev = 1'b0;
  int cnt = 0;
  logic [27:0] w = '0;
  initial begin
    word_o = '0;
    got_o = 1'b0;
    hi_o = '0;
  end
  always @(posedge clk_i) begin
    got_o <= 1'b0;
    prev <= lane_clk_i;
    cnt = (lane_clk_i && !prev) ? 0 : cnt + 1;
    if (cnt % bl_i == bl_i / 2 && cnt / bl_i < 7) begin
      for (int l = 0; l < 4; l++) w[7 * l + cnt / bl_i] = lane_data_i[l];
    end
    if (!lane_clk_i && prev) hi_o <= 8'(cnt);
    if (cnt == 7 * bl_i - 1 && en_i) begin
      word_o <= w;
      got_o <= 1'b1;
    end
  end
endmodule : rls_rx_model

// File: test/tb.sv
/*
 Testbench of the serializer: power, lock, single and dual mode, a long burst through the FIFO.
 Assumes a 100 MHz system clock and a free 160 ns pixel clock.
*/
module tb import rls_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, pix = 1'b0, hs = 1'b0, vs = 1'b0, de = 1'b0;
  logic [7:0] r = '0, g = '0, b = '0;
  logic mode = 1'b0, esel = 1'b1, pdn = 1'b0;
  logic [3:0] da, db;
  logic ca, ea, cb, eb, lk, ov, ga, gb;
  logic [27:0] wa, wb;
  logic [7:0] ha, hb;
  logic [27:0] qa[$], qb[$];
  int n_fail = 0, checked = 0, cyc = 0, n_word = 0;
  always #5 clk_i = ~clk_i;
  initial begin
    #3;
    forever #80 pix = ~pix;
  end
  rls_serializer #(.LOCK_CYCLES_P(50)) rls_serializer_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pix_clk_i(pix),
    .red_i(r), .green_i(g), .blue_i(b), .hsync_i(hs), .vsync_i(vs), .de_i(de),
    .pixel_output_mode_select_i(mode), .capture_edge_select_i(esel), .power_down_n_i(pdn),
    .lane_group_a_data_o(da), .lane_group_a_clk_o(ca), .lane_group_a_en_o(ea), .lane_group_b_data_o(db),
    .lane_group_b_clk_o(cb), .lane_group_b_en_o(eb), .locked_o(lk), .overflow_o(ov));
  rls_rx_model rx_a (.clk_i(clk_i), .en_i(lk), .bl_i(mode ? 4'h4 : 4'h2), .lane_clk_i(ca), .lane_data_i(da),
    .word_o(wa), .got_o(ga), .hi_o(ha));
  rls_rx_model rx_b (.clk_i(clk_i), .en_i(lk), .bl_i(4'h4), .lane_clk_i(cb), .lane_data_i(db),
    .word_o(wb), .got_o(gb), .hi_o(hb));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  always @(posedge clk_i) begin
    cyc++;
    if (ga && wa[26]) begin
      n_word++;
      chk({4'h0, wa}, qa.size() ? {4'h0, qa.pop_front()} : 32'hffff);
    end
    if (gb && wb[26]) chk({4'h0, wb}, qb.size() ? {4'h0, qb.pop_front()} : 32'hffff);
    if (cyc == 30000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic pix_out(input logic [26:0] w, input int grp);
    if (esel) @(negedge pix);
    else @(posedge pix);
    @(negedge clk_i);
    {de, vs, hs, b, g, r} = w;
    if (grp == 1) qa.push_back({1'b0, w});
    if (grp == 2) qb.push_back({1'b0, w});
  endtask : pix_out
  task automatic power_up(input logic m, input logic e);
    @(negedge clk_i);
    pdn = 1'b0;
    repeat (4) @(negedge clk_i);
    chk({ea, eb, lk, ov}, 32'h0);
    mode = m;
    esel = e;
    pdn = 1'b1;
    repeat (3) @(negedge clk_i);
    chk({ea, lk}, 32'h0);
    for (int i = 0; i < 400 && !lk; i++) @(negedge clk_i);
    chk({ea, eb, lk}, {29'h0, 1'b1, m, 1'b1});
  endtask : power_up
  task automatic drain();
    for (int i = 0; i < 600 && (qa.size() || qb.size()); i++) @(negedge clk_i);
    chk(qa.size() + qb.size(), 0);
    for (int i = 0; i < 40 && ca; i++) @(negedge clk_i);
    chk({da, ca, ha}, {mode ? 32'h10 : 32'h8});
  endtask : drain
  task automatic t_single(input logic e);
    power_up(1'b0, e);
    for (int i = 0; i < 6; i++) pix_out({3'h4 | 3'(i), 24'h5a3c00 ^ 24'(i * 24'h010203)}, 1);
    pix_out('0, 0);
    drain();
    chk({eb, cb, db}, 32'h0);
  endtask : t_single
  task automatic t_dual();
    power_up(1'b1, 1'b1);
    pix_out('0, 0);
    pix_out('0, 0);
    for (int i = 0; i < 8; i++) begin
      pix_out({3'h4, 24'hc0ffee + 24'(i)}, 1 + i % 2);
      if (i == 3) repeat (2) pix_out('0, 0);
    end
    pix_out('0, 0);
    pix_out('0, 0);
    drain();
    chk({eb, hb}, 32'h110);
  endtask : t_dual
  task automatic t_burst();
    int start;
    power_up(1'b0, 1'b1);
    start = n_word;
    for (int i = 0; i < 20; i++) pix_out({3'h4, 24'h123456 + 24'(i * 24'h111)}, 1);
    pix_out('0, 0);
    drain();
    chk(n_word - start, 20);
    chk({ov, lk, eb}, 32'h2);
  endtask : t_burst
  initial begin
    repeat (3) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk({ea, eb, lk, da}, 32'h0);
    t_single(1'b1);
    t_single(1'b0);
    t_dual();
    t_burst();
    final_report();
  end
endmodule : tb
